// ===== logic/qtd_time_of_day.sv
// Purpose: Quarter-second time-of-day counter with match, flags and clock out.
// Assumes: Reference clocks arrive as pins slower than half of clock.
// Notes:   Registers sit on a plain port with read data one cycle later.
//
// Contract
// - Eight-bit counter wraps after 256 counts.
// - Counter advances only on 4 Hz tick.
// - Counter reset clears counter and timebase.
// - Enabled match sets flag, clears upper bits.
// - Six-bit match value compared to upper bits.
// - Match write captures counter low two bits.
// - Match clearing keeps low two bits.
// - Lower match value waits for wraparound.
// - Change match two counts away from it.
// - Match irq enable gates request only.
// - Match writes ignored while write pending.
// - Source select picks one of three references.
// - Reset defaults suit 32.768 kHz oscillator.
// - Prescaler code picks divider to 4 Hz.
// - Clock output frequency follows prescaler code.
// - Clock output driven only when enabled.
// - Count register reads the present counter.
// - Quarter flag each count, second every fourth.
// - Flags set regardless, clear by writing one.
// - Reset clears settings, prescaler code 001.
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "qtd_consts.svh"

module qtd_time_of_day #(
  parameter logic [7:0][22:0] PRESCALE_DIV = {`QTD_DIV_PS7, `QTD_DIV_PS6,
                                             `QTD_DIV_PS5, `QTD_DIV_PS4,
                                             `QTD_DIV_PS3, `QTD_DIV_PS2,
                                             `QTD_DIV_PS1, `QTD_DIV_PS0}
) (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       external_osc_clock,
  input  wire logic       low_power_1khz_osc,
  input  wire logic       internal_reference_clock,
  output logic            clock_out,
  output logic            irq
);

  // Register state.
  qtd_pkg::qtd_ctrl_s    ctrl_ff;         // Control fields.
  qtd_pkg::qtd_enables_s en_ff;           // Interrupt and match enables.
  qtd_pkg::qtd_flags_s   flags_ff;        // Sticky event flags.
  logic [5:0]            match_value_ff;  // Upper compare bits.
  logic [1:0]            match_qbits_ff;  // Captured low counter bits.
  logic                  pending_ff;      // Match write still in flight.
  logic [7:0]            count_ff;        // Quarter-second counter.
  logic [22:0]           ps_cnt_ff;       // Reference edges within a tick.
  logic [8:0]            cko_cnt_ff;      // Reference edges within a clock out period.
  logic [7:0]            rdata_ff;        // Registered read data.
  logic                  cko_ff;          // Registered clock output.
  logic                  irq_ff;          // Registered interrupt request.

  // Synchronised reference levels and rise pulses.
  // Each pin has its own synchroniser, so a source switch never waits for a refill.
  logic [2:0] ref_level;
  logic [2:0] ref_rise;

  qtd_edge_sync u_sync_ext (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .async_in (external_osc_clock),
    .level_out(ref_level[0]),
    .rise_out (ref_rise[0])
  );

  qtd_edge_sync u_sync_lpo (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .async_in (low_power_1khz_osc),
    .level_out(ref_level[1]),
    .rise_out (ref_rise[1])
  );

  qtd_edge_sync u_sync_int (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .async_in (internal_reference_clock),
    .level_out(ref_level[2]),
    .rise_out (ref_rise[2])
  );

  // Register port decode.
  wire wr_ctrl  = reg_wr && (reg_addr == `QTD_OFS_CONTROL);
  wire wr_stat  = reg_wr && (reg_addr == `QTD_OFS_STATUS);
  wire wr_match = reg_wr && (reg_addr == `QTD_OFS_MATCH);

  // A counter reset strobe is a control write with its bit set.
  wire cnt_rst = wr_ctrl && reg_wdata[`QTD_CTL_CNTRST_BIT];

  wire match_take = wr_match && !pending_ff;

  // reference select mux
  // The reserved code selects nothing, so the block simply stops counting.
  wire [1:0] src_sel = ctrl_ff.clock_source_select;
  wire src_valid = (src_sel != qtd_pkg::QTD_SRC_RESERVED);
  // Pad the three pins to four, so the reserved code indexes a constant low.
  wire [3:0] level_pad = {1'b0, ref_level};
  wire [3:0] rise_pad  = {1'b0, ref_rise};
  wire sel_level = level_pad[src_sel];
  wire sel_rise  = rise_pad[src_sel];

  wire [22:0] ps_div  = PRESCALE_DIV[ctrl_ff.prescaler_setting];
  wire        ps_last = (ps_cnt_ff == (ps_div - 23'h000001));

  // count only on tick
  // A disabled block holds the timebase at zero, so no tick can leak out.
  wire tick = ctrl_ff.module_enable && sel_rise && ps_last;

  wire [7:0] count_inc = count_ff + 8'h01;

  // equality only, so a lower value needs wraparound
  // Comparing the incremented value flags the match on the very tick that
  // reaches the stored value, so the cleared count shows that value only when its upper six bits are zero.
  wire match_hit = tick && en_ff.match_function_enable &&
                   (count_inc == {match_value_ff, match_qbits_ff});

  // quarter and second events
  // The one-second event follows the low two bits, which a match never
  // touches, so seconds stay evenly spaced across match clears.
  wire qsec_evt = tick;
  wire sec_evt  = tick && (count_inc[1:0] == 2'h0);

  wire clr_q = wr_stat && reg_wdata[`QTD_ST_QSEC_BIT];
  wire clr_s = wr_stat && reg_wdata[`QTD_ST_SEC_BIT];
  wire clr_m = wr_stat && reg_wdata[`QTD_ST_MATCH_BIT];

  // Set wins over a same-cycle write-one clear, so no event is ever lost.
  qtd_pkg::qtd_flags_s nxt_flags;
  assign nxt_flags.quarter_second_flag = qsec_evt | (flags_ff.quarter_second_flag & ~clr_q);
  assign nxt_flags.one_second_flag     = sec_evt  | (flags_ff.one_second_flag & ~clr_s);
  assign nxt_flags.match_flag          = match_hit | (flags_ff.match_flag & ~clr_m);

  logic [8:0] cko_div;
  always_comb begin
    case (ctrl_ff.prescaler_setting)
      3'h4:    cko_div = `QTD_CKO_PS4;
      3'h5:    cko_div = `QTD_CKO_PS5;
      3'h6:    cko_div = `QTD_CKO_PS6;
      3'h7:    cko_div = `QTD_CKO_PS7;
      default: cko_div = 9'h001;
    endcase
  end

  // Pass-through codes forward the synchronised level three clocks late;
  // the divided codes count reference rises instead.
  wire       cko_last    = (cko_cnt_ff == (cko_div - 9'h001));
  wire       cko_pass    = (ctrl_ff.prescaler_setting >= 3'h1) &&
                           (ctrl_ff.prescaler_setting <= 3'h3);
  wire       cko_divided = ctrl_ff.prescaler_setting[2];
  // Odd divisors give a low phase one edge longer than the high phase.
  wire       cko_div_lvl = (cko_cnt_ff < {1'b0, cko_div[8:1]});

  wire nxt_cko = ctrl_ff.clock_output_enable &&
                 ((cko_pass && sel_level) || (cko_divided && cko_div_lvl));

  // enable gates only the request
  // The request is a level that falls only once every enabled flag is clear.
  wire nxt_irq = (flags_ff.quarter_second_flag & en_ff.quarter_second_irq_enable) |
                 (flags_ff.one_second_flag & en_ff.one_second_irq_enable) |
                 (flags_ff.match_flag & en_ff.match_irq_enable);

  // count readable any time
  // Reads have no side effects, so software may poll any register freely.
  logic [7:0] rd_mux;
  always_comb begin
    case (reg_addr)
      `QTD_OFS_CONTROL: rd_mux = {ctrl_ff.module_enable, ctrl_ff.clock_source_select,
                                  1'b0, ctrl_ff.clock_output_enable,
                                  ctrl_ff.prescaler_setting};
      `QTD_OFS_STATUS:  rd_mux = {flags_ff, en_ff, pending_ff};
      `QTD_OFS_MATCH:   rd_mux = {match_value_ff, match_qbits_ff};
      `QTD_OFS_COUNT:   rd_mux = count_ff;
      default:          rd_mux = 8'h00;
    endcase
  end

  // Control register; the counter reset bit always reads back as zero.
  // reset defaults
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl_ff <= '{1'b0, qtd_pkg::qtd_src_e'(`QTD_RST_SRC), 1'b0, `QTD_RST_PS};
    end else if (wr_ctrl) begin
      ctrl_ff <= '{reg_wdata[`QTD_CTL_ENABLE_BIT],
                   qtd_pkg::qtd_src_e'(reg_wdata[`QTD_CTL_SRC_HI:`QTD_CTL_SRC_LO]),
                   reg_wdata[`QTD_CTL_CLKOUT_BIT],
                   reg_wdata[`QTD_CTL_PS_HI:`QTD_CTL_PS_LO]};
    end
  end

  // Status enables and sticky flags.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      en_ff    <= '0;
      flags_ff <= '0;
    end else begin
      flags_ff <= nxt_flags;
      if (wr_stat) begin
        en_ff <= reg_wdata[`QTD_ST_QUARTER_SECOND_IRQ_ENABLE_BIT:`QTD_ST_MATCHEN_BIT];
      end
    end
  end

  // Match register and its write-pending flag.
  // The write is treated as landing in the reference domain on the next
  // reference edge, which is when the pending flag drops.
  // new value compares at once
  // A write in the cycle of a tick still meets the old value at that edge.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      match_value_ff <= `QTD_RST_MATCH;
      match_qbits_ff <= 2'h0;
      pending_ff     <= 1'b0;
    end else if (match_take) begin
      match_value_ff <= reg_wdata[7:2];
      match_qbits_ff <= count_ff[1:0];
      pending_ff     <= 1'b1;
    end else if (sel_rise || !src_valid) begin
      pending_ff <= 1'b0;
    end
  end

  // Prescaler: counts reference edges; cleared while disabled or on reset strobe.
  // Limitation: only rises that reach the logic are counted, so a reference
  // faster than half of clock loses edges and the timebase runs slow.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ps_cnt_ff <= 23'h000000;
    end else if (cnt_rst || !ctrl_ff.module_enable) begin
      ps_cnt_ff <= 23'h000000;
    end else if (sel_rise) begin
      ps_cnt_ff <= ps_last ? 23'h000000 : (ps_cnt_ff + 23'h000001);
    end
  end

  // Quarter-second counter. Disabling the module restarts it from zero.
  // Priority: strobe and disable first, then a match, then a plain tick.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      count_ff <= `QTD_RST_COUNT;
    end else if (cnt_rst || !ctrl_ff.module_enable) begin
      count_ff <= `QTD_RST_COUNT;
    end else if (match_hit) begin
      count_ff <= {6'h00, count_inc[1:0]};
    end else if (tick) begin
      count_ff <= count_inc;
    end
  end

  // Clock output divider, free of the module enable so peripherals keep it.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cko_cnt_ff <= 9'h000;
    end else if (sel_rise) begin
      cko_cnt_ff <= cko_last ? 9'h000 : (cko_cnt_ff + 9'h001);
    end
  end

  // Registered outputs.
  // Every top-level output comes straight from one of these flops.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rdata_ff <= 8'h00;
      cko_ff   <= 1'b0;
      irq_ff   <= 1'b0;
    end else begin
      rdata_ff <= reg_rd ? rd_mux : 8'h00;
      cko_ff   <= nxt_cko;
      irq_ff   <= nxt_irq;
    end
  end

  assign reg_rdata = rdata_ff;
  assign clock_out = cko_ff;
  assign irq       = irq_ff;

endmodule

// ===== logic/qtd_consts.svh
// Purpose: Offsets, field positions, reset values and divider counts of the
//          quarter-second time-of-day counter.
// Assumes: Included by its bare name from the top module.
// Notes:   Definitions only; no logic lives here.
`ifndef QTD_CONSTS_SVH
`define QTD_CONSTS_SVH

// Register offsets on the plain register port.
`define QTD_OFS_CONTROL      2'h0
`define QTD_OFS_STATUS       2'h1
`define QTD_OFS_MATCH        2'h2
`define QTD_OFS_COUNT        2'h3

// Control register field positions.
`define QTD_CTL_ENABLE_BIT   7
`define QTD_CTL_SRC_HI       6
`define QTD_CTL_SRC_LO       5
`define QTD_CTL_CNTRST_BIT   4
`define QTD_CTL_CLKOUT_BIT   3
`define QTD_CTL_PS_HI        2
`define QTD_CTL_PS_LO        0

// Status register field positions.
`define QTD_ST_QSEC_BIT      7
`define QTD_ST_SEC_BIT       6
`define QTD_ST_MATCH_BIT     5
`define QTD_ST_QUARTER_SECOND_IRQ_ENABLE_BIT    4
`define QTD_ST_ONE_SECOND_IRQ_ENABLE_BIT     3
`define QTD_ST_MATCHIE_BIT   2
`define QTD_ST_MATCHEN_BIT   1
`define QTD_ST_PEND_BIT      0

// Reset values.
`define QTD_RST_SRC          2'h0
`define QTD_RST_PS           3'h1
`define QTD_RST_COUNT        8'h00
`define QTD_RST_MATCH        6'h00

// Reference edges per 4 Hz tick for each prescaler code 000 to 111.
`define QTD_DIV_PS0          23'h0000FA
`define QTD_DIV_PS1          23'h002000
`define QTD_DIV_PS2          23'h001F40
`define QTD_DIV_PS3          23'h002580
`define QTD_DIV_PS4          23'h12C000
`define QTD_DIV_PS5          23'h0F4240
`define QTD_DIV_PS6          23'h1E8480
`define QTD_DIV_PS7          23'h3D0900

// Reference edges per clock output period for the divided codes 100 to 111.
`define QTD_CKO_PS4          9'h080
`define QTD_CKO_PS5          9'h07D
`define QTD_CKO_PS6          9'h0FA
`define QTD_CKO_PS7          9'h1F4

`endif

// ===== logic/qtd_pkg.sv
// Purpose: Types shared by the time-of-day counter files.
// Assumes: Constants come from qtd_consts.svh.
// Notes:   Types only; every use is written with the package scope.
package qtd_pkg;

  // Reference clock choices of the source select field.
  typedef enum logic [1:0] {
    QTD_SRC_EXT_OSC  = 2'h0,
    QTD_SRC_LPO_1K   = 2'h1,
    QTD_SRC_INT_REF  = 2'h2,
    QTD_SRC_RESERVED = 2'h3
  } qtd_src_e;

  // Stored control fields; the counter reset bit is a strobe and not held.
  typedef struct packed {
    logic       module_enable;
    qtd_src_e   clock_source_select;
    logic       clock_output_enable;
    logic [2:0] prescaler_setting;
  } qtd_ctrl_s;

  // Sticky event flags.
  typedef struct packed {
    logic quarter_second_flag;
    logic one_second_flag;
    logic match_flag;
  } qtd_flags_s;

  // Software enables held in the status register.
  typedef struct packed {
    logic quarter_second_irq_enable;
    logic one_second_irq_enable;
    logic match_irq_enable;
    logic match_function_enable;
  } qtd_enables_s;

endpackage

// ===== logic/qtd_edge_sync.sv
// Purpose: Two-stage synchroniser for one reference clock pin with a rise pulse.
// Assumes: The pin toggles well below half the system clock rate.
// Notes:   The edge detector reads only the second and third stages.
`timescale 1ns/1ps

module qtd_edge_sync (
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic async_in,
  output logic      level_out,
  output logic      rise_out
);

  logic meta_ff;  // First stage, read by the second stage only.
  logic sync_ff;  // Second stage, a safe level.
  logic prev_ff;  // Delayed copy used for edge detection.

  // Shift the pin through the stages; reset takes constants only.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign level_out = sync_ff;
  assign rise_out  = sync_ff & ~prev_ff;

endmodule

// ===== verification/qtd_time_of_day_asserts.sv
// Purpose: Port checks for the quarter-second time-of-day counter.
// Assumes: The register master leaves one idle cycle between strobes.
// Notes:   Bound to every instance of the top module.
`timescale 1ns/1ps

module qtd_time_of_day_asserts (
  input wire logic       clock,
  input wire logic       sys_rst,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       clock_out,
  input wire logic       irq
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  // Register port steps that the properties are built from.
  sequence s_wr(a);
    reg_wr && reg_addr == a;
  endsequence
  sequence s_rd(a);
    reg_rd && reg_addr == a;
  endsequence
  sequence s_gap;
    !reg_wr && !reg_rd;
  endsequence

  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside its answer cycle");
  AST_CNT_RESET: assert property (s_wr(2'h0) ##0 reg_wdata[4] ##1 s_gap ##1 s_rd(2'h3)
    |=> reg_rdata == 8'h00) else $error("count not cleared by counter reset");
  AST_CNT_DISABLED: assert property (s_wr(2'h0) ##0 !reg_wdata[7] ##1 s_gap ##1
    s_rd(2'h3) |=> reg_rdata == 8'h00) else $error("count moved while disabled");
  AST_CTL_READ: assert property (s_wr(2'h0) ##1 s_gap ##1 s_rd(2'h0) |=>
    reg_rdata == ($past(reg_wdata, 3) & 8'hEF)) else $error("control read back wrong");
  AST_IRQ_MAP: assert property ($past(reg_rd && reg_addr == 2'h1) |-> irq ==
    |(reg_rdata[7:5] & reg_rdata[4:2])) else $error("request differs from flags");
  AST_IRQ_OFF: assert property (s_wr(2'h1) ##0 reg_wdata[4:2] == 3'h0 |=> ##1 !irq)
    else $error("request with all enables off");
  AST_CKO_OFF: assert property (s_wr(2'h0) ##0 !reg_wdata[3] ##1 s_gap |=> !clock_out)
    else $error("clock output driven while disabled");
  AST_RST_QUIET: assert property ($fell(sys_rst) |-> !irq && !clock_out)
    else $error("outputs active right after reset");
endmodule

bind qtd_time_of_day qtd_time_of_day_asserts qtd_time_of_day_asserts_i (
  .clock     (clock),
  .sys_rst   (sys_rst),
  .reg_addr  (reg_addr),
  .reg_wdata (reg_wdata),
  .reg_wr    (reg_wr),
  .reg_rd    (reg_rd),
  .reg_rdata (reg_rdata),
  .clock_out (clock_out),
  .irq       (irq)
);

// ===== verification/qtd_time_of_day_tb_top.sv
// Purpose: Register-level tests of the time-of-day counter.
// Assumes: Reference pins are pulsed by the bench, slow against clock.
// Notes:   Prescale code c is shortened to c+2 reference rises a tick.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end

module qtd_time_of_day_tb_top;
  logic       clock;
  logic       sys_rst;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic [2:0] ref_pins;   // Bit n is the pin of source code n.
  logic       clock_out;
  logic       irq;
  logic [7:0] rv;
  logic [1:0] s;
  int         error_cnt;
  int         cmp_count;
  int         cyc;
  int         hi;         // Rises seen with the divided clock output high.

  qtd_time_of_day #(.PRESCALE_DIV({23'h9, 23'h8, 23'h7, 23'h6, 23'h5, 23'h4, 23'h3,
    23'h2})) qtd_time_of_day_i (
    .clock                    (clock),
    .sys_rst                  (sys_rst),
    .reg_addr                 (reg_addr),
    .reg_wdata                (reg_wdata),
    .reg_wr                   (reg_wr),
    .reg_rd                   (reg_rd),
    .reg_rdata                (reg_rdata),
    .external_osc_clock       (ref_pins[0]),
    .low_power_1khz_osc       (ref_pins[1]),
    .internal_reference_clock (ref_pins[2]),
    .clock_out                (clock_out),
    .irq                      (irq)
  );

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // One strobe a call; the next call waits an edge, so strobes never merge.
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // Rises on the masked pins, then time for the last to reach the logic.
  task automatic pulse(input logic [2:0] m, input int n);
    repeat (n) begin
      @(posedge clock);
      ref_pins <= m;
      repeat (4) @(posedge clock);
      ref_pins <= 3'h0;
      repeat (3) @(posedge clock);
    end
    repeat (4) @(posedge clock);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // A hang counts as a mismatch; the tests need about 10200 cycles.
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end

  initial begin
    {sys_rst, reg_addr, reg_wdata, reg_wr, reg_rd, ref_pins} <= 16'h8000;
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    for (int a = 0; a < 4; a++) begin
      rd(2'(a), rv); `CHK("reset value", (a == 0) ? 8'h01 : 8'h00, rv)
    end
    wr(2'h3, 8'hAA);
    rd(2'h3, rv); `CHK("count read only", 8'h00, rv)
    $display("test reset done");
    // Every prescale code, sources in turn, other pins pulsed as noise.
    for (int c = 0; c < 8; c++) begin
      s = 2'(c % 3);
      wr(2'h0, {1'b0, s, 2'b10, c[2:0]});
      rd(2'h3, rv); `CHK("count cleared", 8'h00, rv)
      wr(2'h0, {1'b1, s, 2'b00, c[2:0]});
      rd(2'h0, rv); `CHK("control", {1'b1, s, 2'b00, c[2:0]}, rv)
      pulse(3'h7 ^ (3'h1 << s), 3);
      pulse(3'h1 << s, 2 * c + 4);
      rd(2'h3, rv); `CHK("count rate", 8'h02, rv)
    end
    $display("test prescale done");
    // Counter reset mid-tick restarts the timebase too.
    // disable before reconfiguring
    wr(2'h0, 8'h27);
    wr(2'h0, 8'h81);
    wr(2'h1, 8'hF0);
    pulse(3'h1, 2);
    wr(2'h0, 8'h91);
    pulse(3'h1, 3);
    rd(2'h3, rv); `CHK("count", 8'h01, rv)
    rd(2'h1, rv); `CHK("status", 8'h90, rv)
    `CHK("irq", 1'b1, irq)
    wr(2'h1, 8'h90);
    rd(2'h1, rv); `CHK("status", 8'h10, rv)
    pulse(3'h1, 9);
    rd(2'h1, rv); `CHK("status", 8'hD0, rv)
    wr(2'h1, 8'hC0);
    rd(2'h1, rv); `CHK("status", 8'h00, rv)
    `CHK("irq", 1'b0, irq)
    $display("test flags done");
    wr(2'h0, 8'h11);
    wr(2'h0, 8'h80);
    pulse(3'h1, 510);
    rd(2'h3, rv); `CHK("count", 8'hFF, rv)
    pulse(3'h1, 2);
    rd(2'h3, rv); `CHK("count wrap", 8'h00, rv)
    $display("test wrap done");
    // Match at 6 with a refused second write.
    wr(2'h0, 8'h10);
    wr(2'h0, 8'h80);
    wr(2'h1, 8'hE0);
    pulse(3'h1, 4);
    wr(2'h2, 8'h04);
    // The rewrite below skips the poll on purpose, to see it dropped.
    wr(2'h2, 8'h08);
    rd(2'h2, rv); `CHK("match", 8'h06, rv)
    rd(2'h1, rv); `CHK("pending", 8'h81, rv)
    pulse(3'h1, 1);
    rd(2'h1, rv); `CHK("pending", 8'h80, rv)
    wr(2'h1, 8'h82);
    pulse(3'h1, 7);
    rd(2'h3, rv); `CHK("count", 8'h02, rv)
    rd(2'h1, rv); `CHK("status", 8'hE2, rv)
    `CHK("irq", 1'b0, irq)
    wr(2'h1, 8'h06);
    rd(2'h1, rv); `CHK("irq", 1'b1, irq)
    pulse(3'h1, 8);
    rd(2'h3, rv); `CHK("count", 8'h02, rv)
    $display("test match done");
    // Pass-through codes follow the pin; code 000 and disable hold low.
    for (int c = 0; c < 4; c++) begin
      wr(2'h0, 8'h08 | 8'(c));
      ref_pins <= 3'h1;
      repeat (8) @(posedge clock);
      #1;
      `CHK("clock out", c != 0, clock_out)
      @(posedge clock);
      ref_pins <= 3'h0;
      repeat (8) @(posedge clock);
      #1;
      `CHK("clock out", 1'b0, clock_out)
    end
    wr(2'h0, 8'h01);
    ref_pins <= 3'h1;
    repeat (8) @(posedge clock);
    #1;
    `CHK("clock out", 1'b0, clock_out)
    @(posedge clock);
    ref_pins <= 3'h0;
    // Code 100 divides by 128; the first 384 rises bring the divider into
    // its period, then half of the next 128 rises must see the output high.
    wr(2'h0, 8'h0C);
    pulse(3'h1, 384);
    hi = 0;
    for (int i = 0; i < 128; i++) begin
      pulse(3'h1, 1);
      #1;
      hi += clock_out;
    end
    `CHK("clock out duty", 64, hi)
    $display("test clock out done");
    end_of_test();
  end
endmodule
